// *** logic/fsps_top.sv ***
// Frame ready flag, converter power-good and start-up sequencing.
// Assumes one AHB-Lite master, decoder frame pulses on hclk, and
// converter threshold comparators arriving asynchronously on pins.
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "fsps_defs.svh"

// How it works
// R1: Frame ready rises after header decode.
// R2: Clear command drops frame ready at once.
// R3: Next frame decode start drops frame ready.
// R4: Status invalid from decode start until ready.
// R5: Controller reads status before next decode.
// R6: Frame periods follow sampling rate and layer.
// R7: Coded frames without fixed period vary spacing.
// R8: Standby while converter start input low.
// R9: Start input held until power good rises.
// R10: Power good needs both sense flags set.
// R11: Power good falls only when both cleared.
// R12: Controller resets device before commands.
// R13: Raise one converter voltage at a time; converter_enable raises both converters together.
// R14: Check power-good flags before enabling blocks.
// R15: Processor data usable 5 ms after enable.
// R16: Controller writes crystal frequency after enable.
// R17: Routing cells, serial bitstream input default.
// R18: Clock output set by its config cell.
// R19: Config writes apply together on commit.
// R20: Volume applied to processor output.
// R21: Codec converters off until switched on.
// R22: Output converters source by mix select.
// R23: Clearing converter enables powers down system.
// R24: Words are 16 bits, high byte first.
// R25: Control register handles reset and tasks.
module fsps_top (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        header_done,
	input  wire logic        decode_start,
	input  wire logic        converter_start_input,
	input  wire logic [1:0]  converter_sense_input,
	output logic             frame_ready,
	output logic             status_valid,
	output logic             power_good_output,
	output logic [1:0]       converter_enable,
	output logic             dsp_enable,
	output logic             dsp_ready,
	output logic             codec_enable,
	output logic [1:0]       codec_conv_on,
	output logic [1:0]       output_source,
	output logic [15:0]      volume,
	output logic [1:0]       input_route,
	output logic [15:0]      output_route,
	output logic [15:0]      clock_output_pin_cfg
);
	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
		end else begin
			sync1_q <= {converter_start_input, converter_sense_input};
			sync2_q <= sync1_q;
		end
	end

	wire logic       start_s = sync2_q[2];
	wire logic [1:0] sense_s = sync2_q[1:0];

	// ------------------------------------------------------------------
	// Bus address phase capture
	// ------------------------------------------------------------------
	logic        wr_q;
	logic        rd_q;
	logic [11:0] addr_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q   <= 1'b0;
			rd_q   <= 1'b0;
			addr_q <= 12'h000;
		end else begin
			wr_q   <= hsel && hready && htrans[1] && hwrite;
			rd_q   <= hsel && hready && htrans[1] && !hwrite;
			addr_q <= haddr[11:0];
		end
	end

	function automatic logic hit(input logic [11:0] off);
		hit = wr_q && (addr_q == off);
	endfunction

	// ------------------------------------------------------------------
	// Control and configuration registers
	// ------------------------------------------------------------------
	logic [15:0] control_q;
	logic [15:0] stage_q;
	logic [15:0] live_q;
	logic [15:0] mix_q;
	logic [15:0] vol_q;
	logic [15:0] codec_q;
	logic        cmd_clr;
	logic        cmd_commit;

	assign cmd_clr    = hit(`FSPS_OFF_CMD) && hwdata[`FSPS_CMD_CLR_SYNC];
	assign cmd_commit = hit(`FSPS_OFF_CMD) && hwdata[`FSPS_CMD_COMMIT];

	// Control word: converter, codec and processor enables.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			control_q <= `FSPS_CONTROL_RST;
		end else if (hit(`FSPS_OFF_CONTROL)) begin // R25
			control_q <= hwdata[15:0]; // R24
		end
	end

	// Staged routing/clock config; only a commit makes it live.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stage_q <= 16'h0000;
			live_q  <= 16'h0000; // R17
		end else begin
			if (hit(`FSPS_OFF_CFG_STAGE)) begin
				stage_q <= hwdata[15:0];
			end
			if (cmd_commit) begin
				live_q <= stage_q; // R19
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mix_q   <= 16'h0000;
			vol_q   <= 16'h0000;
			codec_q <= 16'h0000; // R21
		end else begin
			if (hit(`FSPS_OFF_MIXSEL)) begin
				mix_q <= hwdata[15:0]; // R22
			end
			if (hit(`FSPS_OFF_VOLUME)) begin
				vol_q <= hwdata[15:0]; // R20
			end
			if (hit(`FSPS_OFF_CODEC_EN)) begin
				codec_q <= hwdata[15:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// Frame ready flag
	// ------------------------------------------------------------------
	logic fr_q;
	logic valid_q;

	// Header completion beats both clear sources so no frame is lost.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fr_q    <= 1'b0;
			valid_q <= 1'b0;
		end else begin
			if (header_done) begin
				fr_q    <= 1'b1; // R1 R6 R7
				valid_q <= 1'b1;
			end else if (decode_start) begin
				fr_q    <= 1'b0; // R3
				valid_q <= 1'b0; // R4
			end else if (cmd_clr) begin
				fr_q <= 1'b0; // R2
			end
		end
	end

	// ------------------------------------------------------------------
	// Power-good and converter sequencing
	// ------------------------------------------------------------------
	logic                pg_q;
	fsps_pkg::fsps_pwr_t pwr_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pg_q <= 1'b0;
		end else if (sense_s == 2'b11) begin
			pg_q <= 1'b1; // R10
		end else if (sense_s == 2'b00) begin
			pg_q <= 1'b0; // R11
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwr_q <= fsps_pkg::FSPS_OFF;
		end else begin
			unique case (pwr_q)
			fsps_pkg::FSPS_OFF: begin
				if (start_s) begin // R8
					pwr_q <= fsps_pkg::FSPS_START;
				end
			end
			fsps_pkg::FSPS_START: begin
				if (pg_q) begin // R9
					pwr_q <= fsps_pkg::FSPS_RUN;
				end
			end
			fsps_pkg::FSPS_RUN: begin
				if (control_q[`FSPS_CTL_DC2_EN:`FSPS_CTL_DC1_EN] == 2'b00) begin
					pwr_q <= fsps_pkg::FSPS_DOWN; // R23
				end
			end
			fsps_pkg::FSPS_DOWN: begin
				if (!start_s) begin
					pwr_q <= fsps_pkg::FSPS_OFF;
				end
			end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Processor initialisation timer
	// ------------------------------------------------------------------
	logic [17:0] init_q;
	logic        ready_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			init_q  <= 18'h00000;
			ready_q <= 1'b0;
		// Counting only while powered keeps dsp_ready behind dsp_enable.
		end else if (!control_q[`FSPS_CTL_DSP_EN]
			|| (pwr_q == fsps_pkg::FSPS_OFF)
			|| (pwr_q == fsps_pkg::FSPS_DOWN)) begin
			init_q  <= 18'h00000;
			ready_q <= 1'b0;
		end else if (init_q == 18'(`FSPS_INIT_CYC - 1)) begin
			ready_q <= 1'b1; // R15
		end else begin
			init_q <= init_q + 18'h00001;
		end
	end

	// ------------------------------------------------------------------
	// Outputs and read data
	// ------------------------------------------------------------------
	logic [31:0] rdata_d;
	logic        on;

	assign on = (pwr_q == fsps_pkg::FSPS_START)
		|| (pwr_q == fsps_pkg::FSPS_RUN);

	always_comb begin
		rdata_d = 32'h00000000;
		unique case (haddr[11:0])
		`FSPS_OFF_CONTROL:   rdata_d = {16'h0000, control_q};
		`FSPS_OFF_DCCF:      rdata_d = {16'h0000, sense_s[1], 7'h00,
			sense_s[0], 7'h00}; // R14
		`FSPS_OFF_CODEC_EN:  rdata_d = {16'h0000, codec_q};
		`FSPS_OFF_STATUS:    rdata_d = {26'h0000000, pwr_q, ready_q,
			pg_q, valid_q, fr_q};
		`FSPS_OFF_CFG_STAGE: rdata_d = {16'h0000, stage_q};
		`FSPS_OFF_CFG_LIVE:  rdata_d = {16'h0000, live_q};
		`FSPS_OFF_MIXSEL:    rdata_d = {16'h0000, mix_q};
		`FSPS_OFF_VOLUME:    rdata_d = {16'h0000, vol_q};
		default:             rdata_d = 32'h00000000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata               <= 32'h00000000;
			hreadyout            <= 1'b1;
			hresp                <= 1'b0;
			frame_ready          <= 1'b0;
			status_valid         <= 1'b0;
			power_good_output    <= 1'b0;
			converter_enable     <= 2'b00;
			dsp_enable           <= 1'b0;
			dsp_ready            <= 1'b0;
			codec_enable         <= 1'b0;
			codec_conv_on        <= 2'b00;
			output_source        <= 2'b00;
			volume               <= 16'h0000;
			input_route          <= `FSPS_ROUTE_SERIAL;
			output_route         <= 16'h0000;
			clock_output_pin_cfg <= 16'h0000;
		end else begin
			if (hsel && hready && htrans[1] && !hwrite) begin
				hrdata <= rdata_d;
			end
			hreadyout            <= 1'b1;
			hresp                <= 1'b0;
			frame_ready          <= fr_q;
			status_valid         <= valid_q;
			power_good_output    <= pg_q;
			converter_enable     <= on ? 2'b11 : 2'b00;
			dsp_enable           <= control_q[`FSPS_CTL_DSP_EN] && on;
			dsp_ready            <= ready_q;
			codec_enable         <= control_q[`FSPS_CTL_CODEC_EN] && on;
			codec_conv_on        <= codec_q[1:0]; // R21
			output_source        <= mix_q[1:0]; // R22
			volume               <= vol_q; // R20
			input_route          <= live_q[1:0]; // R17
			output_route         <= {14'h0000, live_q[3:2]};
			clock_output_pin_cfg <= {8'h00, live_q[15:8]}; // R18
		end
	end
endmodule
`default_nettype wire

// *** logic/fsps_defs.svh ***
// Constants for the frame sync and power sequencing block.
// Assumes a 40 MHz hclk and an AHB-Lite master with 32-bit words.
`ifndef FSPS_DEFS_SVH
`define FSPS_DEFS_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
// Control-side registers keep their word index; the bus sees index * 4,
// so every register sits in one aligned word.
`define FSPS_IDX_CONTROL   10'h06a
`define FSPS_IDX_DCCF      10'h076
`define FSPS_IDX_CODEC_EN  10'h06c
`define FSPS_OFF_CONTROL   {`FSPS_IDX_CONTROL, 2'b00}
`define FSPS_OFF_DCCF      {`FSPS_IDX_DCCF, 2'b00}
`define FSPS_OFF_CODEC_EN  {`FSPS_IDX_CODEC_EN, 2'b00}
`define FSPS_OFF_STATUS    12'h100
`define FSPS_OFF_CMD       12'h104
`define FSPS_OFF_CFG_STAGE 12'h108
`define FSPS_OFF_CFG_LIVE  12'h10c
`define FSPS_OFF_MIXSEL    12'h110
`define FSPS_OFF_VOLUME    12'h114

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define FSPS_CTL_DC2_EN    13
`define FSPS_CTL_DC1_EN    12
`define FSPS_CTL_CODEC_EN  11
`define FSPS_CTL_DSP_EN    10
`define FSPS_CONTROL_RST   16'h3000
`define FSPS_DCCF_PG2      15
`define FSPS_DCCF_PG1      7
`define FSPS_CMD_CLR_SYNC  0
`define FSPS_CMD_COMMIT    1
`define FSPS_ROUTE_SERIAL  2'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define FSPS_CLK_HZ        40000000
`define FSPS_INIT_MS       5
`define FSPS_INIT_CYC      ((`FSPS_CLK_HZ / 1000) * `FSPS_INIT_MS)

`endif

// *** logic/fsps_pkg.sv ***
// Types for the frame sync and power sequencing block.
// Assumes fsps_defs.svh holds all numeric constants.
package fsps_pkg;
	typedef enum logic [1:0] {
		FSPS_OFF    = 2'b00,
		FSPS_START  = 2'b01,
		FSPS_RUN    = 2'b10,
		FSPS_DOWN   = 2'b11
	} fsps_pwr_t;
endpackage

// *** tb/fsps_conv_model.sv ***
// Behavioural model of the two converters behind the sense pins.
// Assumes the converter enables of fsps_top, sampled on hclk.
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Converter model
// ----------------------------------------------------------------------
module fsps_conv_model (
	input  wire logic       hclk,
	input  wire logic [1:0] converter_enable,
	input  wire logic [1:0] sag,
	output logic      [1:0] converter_sense_input
);
	logic [7:0] ramp1_q = 8'h00;
	logic [7:0] ramp2_q = 8'h00;
	// Converter 2 ramps slowly, so power-good must wait for the later one.
	always_ff @(posedge hclk) begin
		ramp1_q <= {ramp1_q[6:0], converter_enable[0]};
		ramp2_q <= {ramp2_q[6:0], converter_enable[1]};
	end
	// A sag models the dip of a voltage change below the monitor level.
	assign converter_sense_input = {ramp2_q[7], ramp1_q[2]} & ~sag;
endmodule
`default_nettype wire

// *** tb/fsps_assertions.sv ***
// Checker for frame ready and power-good at the ports of fsps_top.
// Assumes one clock hclk and the asynchronous low reset hresetn.
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Checker
// ----------------------------------------------------------------------
module fsps_chk (
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic       header_done,
	input wire logic       decode_start,
	input wire logic       converter_start_input,
	input wire logic [1:0] converter_sense_input,
	input wire logic       frame_ready,
	input wire logic       status_valid,
	input wire logic       power_good_output,
	input wire logic [1:0] converter_enable,
	input wire logic       dsp_enable,
	input wire logic       dsp_ready
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_FR_SET: assert property (header_done |-> ##2 frame_ready)
		else $error("frame ready late");
	AST_FR_CAUSE: assert property ($rose(frame_ready) |-> $past(header_done, 2))
		else $error("frame ready without header");
	AST_FR_DROP: assert property (decode_start && !header_done |-> ##2 !frame_ready)
		else $error("frame ready kept over decode");
	AST_SV_DROP: assert property (decode_start && !header_done |-> ##2 !status_valid)
		else $error("status kept over decode");
	AST_PG_NEED: assert property ((converter_sense_input != 2'b11)[*6] |=> !$rose(power_good_output))
		else $error("power good with one flag");
	AST_PG_SET: assert property ((converter_sense_input == 2'b11)[*8] |-> power_good_output)
		else $error("power good missing");
	AST_PG_KEEP: assert property ((converter_sense_input != 2'b00)[*6] |=> !$fell(power_good_output))
		else $error("power good fell early");
	AST_STANDBY: assert property ((!converter_start_input)[*4] ##0 converter_enable == 2'b00 |=> converter_enable == 2'b00)
		else $error("left standby");
	AST_DSP_RDY: assert property (dsp_ready |-> $past(dsp_enable))
		else $error("processor ready while off");
	cover property (header_done ##2 frame_ready);
	cover property ($rose(power_good_output));
	cover property (decode_start && frame_ready);
endmodule
bind fsps_top fsps_chk fsps_chk_i (.hclk, .hresetn, .header_done,
	.decode_start, .converter_start_input, .converter_sense_input,
	.frame_ready, .status_valid, .power_good_output, .converter_enable,
	.dsp_enable, .dsp_ready);
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench of fsps_top over AHB-Lite with a converter model.
// Assumes hreadyout is the only slave's ready and read data is queued.
`timescale 1ns/1ps
`default_nettype none
`include "fsps_defs.svh"
// ----------------------------------------------------------------------
// Bench
// ----------------------------------------------------------------------
module testbench;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	wire logic   hready;
	logic [31:0] hrdata;
	logic        hreadyout, hresp, power_good_output, rd_ph = 1'b0;
	logic        header_done = 1'b0, decode_start = 1'b0;
	logic        converter_start_input = 1'b0;
	logic [1:0]  sag = 2'h0, sense, converter_enable;
	logic [15:0] volume, output_route, clock_output_pin_cfg;
	logic [1:0]  output_source, input_route, codec_conv_on;
	logic        codec_enable, dsp_enable;
	logic [31:0] exp_q[$];
	logic [31:0] v;
	int          n_errors = 0, checks_done = 0;

	assign hready = hreadyout;
	always #12.5 hclk = ~hclk;

	fsps_top fsps_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .header_done,
		.decode_start, .converter_start_input,
		.converter_sense_input(sense), .frame_ready(), .status_valid(),
		.power_good_output, .converter_enable, .dsp_enable, .dsp_ready(),
		.codec_enable, .codec_conv_on, .output_source, .volume,
		.input_route, .output_route, .clock_output_pin_cfg);
	fsps_conv_model fsps_conv_model_i (.hclk, .converter_enable, .sag,
		.converter_sense_input(sense));

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask

	// Reads settle first, since status flags lag their causes by a few flops.
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		repeat (8) @(posedge hclk);
		exp_q.push_back(e);
		bus(a, 1'b0, 32'h0);
	endtask

	task automatic pulse(input logic h, input logic s);
		header_done <= h;
		decode_start <= s;
		@(posedge hclk);
		header_done <= 1'b0;
		decode_start <= 1'b0;
		repeat (4 + $urandom_range(0, 5)) @(posedge hclk);
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge hclk) begin
		if (rd_ph && hreadyout === 1'b1)
			chk(hrdata, exp_q.pop_front());
		rd_ph <= hsel && hready && htrans[1] && !hwrite;
	end

	initial begin
		#1000000;
		n_errors++;
		summarize();
	end

	initial begin
		void'($urandom(32'hc56e));
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(`FSPS_OFF_CONTROL, 32'h3000);
		rd(12'h200, 32'h0);
		rd(`FSPS_OFF_CFG_LIVE, 32'h0);
		$display("test reset done");
		pulse(1'b1, 1'b0);
		rd(`FSPS_OFF_STATUS, 32'h3);
		wr(`FSPS_OFF_CMD, 32'h1);
		rd(`FSPS_OFF_STATUS, 32'h2);
		pulse(1'b1, 1'b0);
		pulse(1'b0, 1'b1);
		rd(`FSPS_OFF_STATUS, 32'h0);
		pulse(1'b1, 1'b1);
		rd(`FSPS_OFF_STATUS, 32'h3);
		pulse(1'b0, 1'b1);
		$display("test frame done");
		v = $urandom;
		wr(`FSPS_OFF_VOLUME, {16'h0, v[15:0]});
		rd(`FSPS_OFF_VOLUME, {16'h0, v[15:0]});
		chk({16'h0, volume}, {16'h0, v[15:0]});
		wr(`FSPS_OFF_MIXSEL, {30'h0, v[1:0]});
		rd(`FSPS_OFF_MIXSEL, {30'h0, v[1:0]});
		chk({30'h0, output_source}, {30'h0, v[1:0]});
		wr(`FSPS_OFF_CFG_STAGE, {16'h0, v[31:16]});
		rd(`FSPS_OFF_CFG_LIVE, 32'h0);
		chk({30'h0, input_route}, {30'h0, `FSPS_ROUTE_SERIAL});
		wr(`FSPS_OFF_CMD, 32'h2);
		rd(`FSPS_OFF_CFG_LIVE, {16'h0, v[31:16]});
		chk({30'h0, input_route}, {30'h0, v[17:16]});
		chk({16'h0, output_route}, {30'h0, v[19:18]});
		chk({16'h0, clock_output_pin_cfg}, {24'h0, v[31:24]});
		$display("test config done");
		converter_start_input <= 1'b1;
		for (int i = 0; i < 200 && power_good_output !== 1'b1; i++)
			@(posedge hclk);
		converter_start_input <= 1'b0;
		rd(`FSPS_OFF_STATUS, {26'h0, fsps_pkg::FSPS_RUN, 4'h4});
		sag <= 2'h1;
		rd(`FSPS_OFF_STATUS, {26'h0, fsps_pkg::FSPS_RUN, 4'h4});
		sag <= 2'h0;
		rd(`FSPS_OFF_DCCF, (32'h1 << `FSPS_DCCF_PG2) | (32'h1 << `FSPS_DCCF_PG1));
		wr(`FSPS_OFF_CONTROL, 32'h3c00);
		wr(12'h200, 32'h0);
		rd(`FSPS_OFF_CONTROL, 32'h3c00);
		chk({31'h0, dsp_enable}, 32'h1);
		chk({31'h0, codec_enable}, 32'h1);
		wr(`FSPS_OFF_CODEC_EN, {30'h0, v[3:2]});
		rd(`FSPS_OFF_CODEC_EN, {30'h0, v[3:2]});
		chk({30'h0, codec_conv_on}, {30'h0, v[3:2]});
		$display("test power done");
		wr(`FSPS_OFF_CONTROL, 32'h0);
		repeat (40) @(posedge hclk);
		rd(`FSPS_OFF_STATUS, 32'h0);
		chk({31'h0, codec_enable}, 32'h0);
		chk({31'h0, dsp_enable}, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		$display("test down done");
		summarize();
	end
endmodule
`default_nettype wire
